// ### rtl/spp_edge.sv
/*
  Edge finder on an already synchronised programmer clock.
  Assumes the input has passed the two-flop synchroniser.
*/
`timescale 1ns/10ps
module spp_edge
  import spp_pkg::*;
(
  input  wire logic clock,
  input  wire logic rst_b,
  input  wire logic level_in,
  output logic      rise_pulse,
  output logic      fall_pulse
);
  logic last_r;
  logic last_nxt;

  // previous level; edges compare against it
  always_comb
  begin
    last_nxt   = level_in;
    rise_pulse = level_in & ~last_r;
    fall_pulse = ~level_in & last_r;
  end

  always_ff @(posedge clock or negedge rst_b)
  begin
    if (!rst_b)
      last_r <= 1'b1;  // programmer clock idles high; no false edge after reset
    else
      last_r <= last_nxt;
  end
endmodule

// ### rtl/spp_link.sv
/*
  Physical layer and message framing of the serial programming port.
  Receives and sends fixed frames on one open data line, finds parity,
  frame, break and collision exceptions, inserts a turnaround guard and
  keeps the access layer's message direction and error state.
  Assumes the programmer clock and data line are asynchronous pins
  sampled by the 100 MHz clock, and that the access layer upstream
  supplies reply bytes on tx_byte whenever tx_byte_req is seen.
*/
// Notes on behaviour
// - frame is start, eight data, parity, two stops
// - data bits go least significant first
// - start bit low, both stop bits high
// - parity is even over the eight bits
// - break is twelve or more low bits
// - drive on falling, sample on rising edge
// - receive mode after reset; access layer switches
// - shift each rising edge through second stop
// - stop bit low gives frame error
// - parity mismatch at frame end gives error
// - all-zero frame gives break exception
// - parity or frame exception enters error, receive mode
// - load shift register, send one frame per byte
// - drive zeros; ones driven one period only
// - released line sampled low means collision
// - collision stops driver, error until break
// - guard plus two idle bits before first reply start
// - guard defaults to 128 bit periods
// - messages start with programmer instruction byte
// - write messages inbound; read messages answered
// - one operand, key takes eight operands
// - error state cleared only by a break
`timescale 1ns/10ps
module spp_link
  import spp_pkg::*;
(
  input  wire logic       clock,
  input  wire logic       rst_b,
  input  wire logic       prog_clk,
  input  wire logic       prog_data_line_in,
  output logic            prog_data_line_out,
  output logic            prog_data_line_oe,
  input  wire logic [7:0] guard_time,
  input  wire logic       guard_load,
  input  wire logic       instr_is_read,
  input  wire logic [7:0] tx_byte,
  output logic            tx_byte_req,
  output logic [7:0]      rx_byte,
  output logic            rx_valid,
  output logic            rx_is_instr,
  output logic            frame_err,
  output logic            parity_err,
  output logic            break_seen,
  output logic            collision,
  output logic            error_state,
  output logic            tx_mode
);
  // ---------------------------------------------------------------
  // pin sampling
  // ---------------------------------------------------------------
  logic clk_s;
  logic data_s;
  logic rise;
  logic fall;

  // clock idles high; reset value matches so no edge appears at release
  spp_sync #(.RESET_VAL(1'b1)) u_clk_sync
  (
    .clock    (clock),
    .rst_b    (rst_b),
    .async_in (prog_clk),
    .sync_out (clk_s)
  );

  spp_sync #(.RESET_VAL(SPP_LINE_IDLE)) u_dat_sync
  (
    .clock    (clock),
    .rst_b    (rst_b),
    .async_in (prog_data_line_in),
    .sync_out (data_s)
  );

  spp_edge u_edge
  (
    .clock      (clock),
    .rst_b      (rst_b),
    .level_in   (clk_s),
    .rise_pulse (rise),
    .fall_pulse (fall)
  );

  // ---------------------------------------------------------------
  // state
  // ---------------------------------------------------------------
  spp_phy_mode_type  mode_r,   mode_nxt;
  logic              busy_r,   busy_nxt;
  logic [3:0]        bit_r,    bit_nxt;
  logic [11:0]       sh_r,     sh_nxt;
  logic              par_r,    par_nxt;
  logic [SPP_CNT_W-1:0] idle_r, idle_nxt;
  logic [4:0]        low_r,    low_nxt;
  logic [7:0]        guard_r,  guard_nxt;
  logic              err_r,    err_nxt;
  logic [3:0]        ops_r,    ops_nxt;
  logic              drv_r,    drv_nxt;
  logic              oe_r,     oe_nxt;
  logic [7:0]        rxb_nxt;
  logic              rxv_nxt, rxi_nxt, fe_nxt, pe_nxt, bk_nxt, col_nxt, req_nxt;
  logic [11:0]       frame_w;
  logic              bad_w;

  // ---------------------------------------------------------------
  // receiver, transmitter and message control
  // ---------------------------------------------------------------
  // one process: mode changes and shifting share the same bit edges
  always_comb
  begin
    mode_nxt  = mode_r;
    busy_nxt  = busy_r;
    bit_nxt   = bit_r;
    sh_nxt    = sh_r;
    par_nxt   = par_r;
    idle_nxt  = idle_r;
    low_nxt   = low_r;
    guard_nxt = guard_load ? guard_time : guard_r;
    err_nxt   = err_r;
    ops_nxt   = ops_r;
    drv_nxt   = drv_r;
    oe_nxt    = oe_r;
    rxb_nxt   = rx_byte;
    rxv_nxt   = 1'b0;
    rxi_nxt   = rx_is_instr;
    fe_nxt    = 1'b0;
    pe_nxt    = 1'b0;
    bk_nxt    = 1'b0;
    col_nxt   = 1'b0;
    req_nxt   = 1'b0;
    frame_w   = {data_s, sh_r[11:1]};
    bad_w     = 1'b0;
    unique case (mode_r)
      SPP_RX_MODE:
      begin
        if (rise)
        begin
          // low run length, saturating at 31; a break still needs the whole frame low
          low_nxt = data_s ? 5'h00 : ((low_r == 5'h1F) ? low_r : low_r + 5'h01);
          if (!busy_r)
          begin
            if (!data_s)
            begin
              busy_nxt = 1'b1;
              bit_nxt  = 4'h1;
              sh_nxt   = 12'h000;
              par_nxt  = 1'b0;
            end
          end
          else
          begin
            sh_nxt  = frame_w;
            bit_nxt = bit_r + 4'h1;
            if (bit_r <= 4'(SPP_DATA_BITS))
              par_nxt = par_r ^ data_s;
            if (bit_r == 4'(SPP_FRAME_BITS - 1))
            begin
              busy_nxt = 1'b0;
              // frame_w[11:1] holds d0..d7, parity, both stops
              if ((frame_w[11:1] == 11'h000) && (low_r >= 5'(SPP_FRAME_BITS - 2)))
              begin
                bk_nxt   = 1'b1;
                err_nxt  = 1'b0;
                ops_nxt  = 4'h0;
              end
              else if (!err_r)
              begin
                fe_nxt = ~(frame_w[10] & frame_w[11]);
                pe_nxt = par_r ^ frame_w[9];
                bad_w  = fe_nxt | pe_nxt;
                if (bad_w)
                  err_nxt = 1'b1;
                else
                begin
                  rxb_nxt = frame_w[8:1];
                  rxv_nxt = 1'b1;
                  rxi_nxt = (ops_r == 4'h0);
                  if (ops_r == 4'h0)
                  begin
                    ops_nxt = (frame_w[8:1] == SPP_KEY_OPCODE) ? SPP_KEY_OPERANDS
                                                               : SPP_STD_OPERANDS;
                    if (instr_is_read)
                    begin
                      mode_nxt = SPP_TX_GUARD;
                      idle_nxt = SPP_CNT_W'(guard_r) + SPP_CNT_W'(SPP_GUARD_MIN);
                      req_nxt  = 1'b1;
                    end
                  end
                  else
                    ops_nxt = ops_r - 4'h1;
                end
              end
            end
          end
        end
      end
      SPP_TX_GUARD:
      begin
        // line released and high during the guard
        if (fall)
        begin
          // each fall with a count left is one idle bit; start follows
          if (idle_r == '0)
          begin
            mode_nxt  = SPP_TX_SHIFT;
            sh_nxt    = {2'b11, ^tx_byte, tx_byte, 1'b0};
            bit_nxt   = 4'h0;
            drv_nxt   = 1'b0;
            oe_nxt    = 1'b1;
          end
          else
            idle_nxt = idle_r - SPP_CNT_W'(1);
        end
      end
      SPP_TX_SHIFT:
      begin
        if (rise && !oe_r && !data_s)
        begin
          // released line pulled low by the far end
          col_nxt  = 1'b1;
          err_nxt  = 1'b1;
          oe_nxt   = 1'b0;
          drv_nxt  = SPP_LINE_IDLE;
          mode_nxt = SPP_RX_MODE;
          ops_nxt  = 4'h0;
          busy_nxt = 1'b0;
        end
        else if (fall)
        begin
          if (bit_r == 4'(SPP_FRAME_BITS - 1))
          begin
            oe_nxt  = 1'b0;
            drv_nxt = SPP_LINE_IDLE;
            ops_nxt = ops_r - 4'h1;
            if (ops_r == 4'h1)
            begin
              mode_nxt = SPP_RX_MODE;
              busy_nxt = 1'b0;
            end
            else
            begin
              mode_nxt = SPP_TX_GUARD;
              idle_nxt = '0;  // the closing fall itself is the one idle bit
              req_nxt  = 1'b1;
            end
          end
          else
          begin
            bit_nxt   = bit_r + 4'h1;
            drv_nxt   = sh_r[1];
            // ones after a one are left to the pull-up
            oe_nxt    = ~sh_r[1] | ~sh_r[0];
            sh_nxt    = {1'b1, sh_r[11:1]};
          end
        end
      end
    endcase
  end

  // registered state and outputs
  always_ff @(posedge clock or negedge rst_b)
  begin
    if (!rst_b)
    begin
      mode_r             <= SPP_RX_MODE;
      busy_r             <= 1'b0;
      bit_r              <= 4'h0;
      sh_r               <= 12'h000;
      par_r              <= 1'b0;
      idle_r             <= '0;
      low_r              <= 5'h00;
      guard_r            <= SPP_GUARD_RESET;
      err_r              <= 1'b0;
      ops_r              <= 4'h0;
      drv_r              <= SPP_LINE_IDLE;
      oe_r               <= 1'b0;
      rx_byte            <= 8'h00;
      rx_valid           <= 1'b0;
      rx_is_instr        <= 1'b0;
      frame_err          <= 1'b0;
      parity_err         <= 1'b0;
      break_seen         <= 1'b0;
      collision          <= 1'b0;
      tx_byte_req        <= 1'b0;
    end
    else
    begin
      mode_r             <= mode_nxt;
      busy_r             <= busy_nxt;
      bit_r              <= bit_nxt;
      sh_r               <= sh_nxt;
      par_r              <= par_nxt;
      idle_r             <= idle_nxt;
      low_r              <= low_nxt;
      guard_r            <= guard_nxt;
      err_r              <= err_nxt;
      ops_r              <= ops_nxt;
      drv_r              <= drv_nxt;
      oe_r               <= oe_nxt;
      rx_byte            <= rxb_nxt;
      rx_valid           <= rxv_nxt;
      rx_is_instr        <= rxi_nxt;
      frame_err          <= fe_nxt;
      parity_err         <= pe_nxt;
      break_seen         <= bk_nxt;
      collision          <= col_nxt;
      tx_byte_req        <= req_nxt;
    end
  end

  // pin and status views, all from flops
  always_comb
  begin
    prog_data_line_out = drv_r;
    prog_data_line_oe  = oe_r;
    error_state        = err_r;
    tx_mode            = (mode_r != SPP_RX_MODE);
  end

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  // released line seen low at a sampling edge while sending
  sequence s_released_low;
    rise && (mode_r == SPP_TX_SHIFT) && !oe_r && !data_s;
  endsequence

  chk_err_no_tx: assert property (@(posedge clock) disable iff (!rst_b)
    err_r |-> (mode_r == SPP_RX_MODE) || $rose(err_r))
    else $error("transmitting while in error state");
  chk_break_clears: assert property (@(posedge clock) disable iff (!rst_b)
    break_seen |-> !err_r)
    else $error("break did not clear error state");
  chk_fe_sets_err: assert property (@(posedge clock) disable iff (!rst_b)
    (frame_err || parity_err) |-> err_r)
    else $error("receive exception without error state");
  chk_col_release: assert property (@(posedge clock) disable iff (!rst_b)
    collision |-> !oe_r && err_r && mode_r == SPP_RX_MODE)
    else $error("driver still on after collision");
  chk_oe_on_zero: assert property (@(posedge clock) disable iff (!rst_b)
    $rose(oe_r) |-> !drv_r)
    else $error("driver re-enabled for a one");
  chk_col_detect: assert property (@(posedge clock) disable iff (!rst_b)
    s_released_low |=> collision && !tx_mode)
    else $error("contention on released line not flagged");
  chk_zero_driven: assert property (@(posedge clock) disable iff (!rst_b)
    (!drv_r) |-> oe_r)
    else $error("zero bit not driven");
  chk_idle_released: assert property (@(posedge clock) disable iff (!rst_b)
    (mode_r == SPP_TX_GUARD) |-> !oe_r)
    else $error("line driven during guard");
  chk_guard_reset: assert property (@(posedge clock) disable iff (!rst_b)
    $rose(rst_b) |-> guard_r == SPP_GUARD_RESET)
    else $error("guard time not at default");
  chk_tx_on_fall: assert property (@(posedge clock) disable iff (!rst_b)
    $changed(drv_r) && mode_r == SPP_TX_SHIFT |-> $past(fall) || $past(mode_r) != SPP_TX_SHIFT)
    else $error("data changed away from falling edge");
  chk_rx_pulse: assert property (@(posedge clock) disable iff (!rst_b)
    rx_valid |=> !rx_valid)
    else $error("receive strobe longer than one cycle");
endmodule

// ### rtl/spp_pkg.sv
/*
  Shared constants for the serial programming port physical layer and
  message framing: frame layout, break length, guard time and message
  lengths.
  Assumes a single system clock that oversamples the programmer clock.
*/
package spp_pkg;
  // frame layout
  localparam int unsigned SPP_DATA_BITS   = 8;
  localparam int unsigned SPP_STOP_BITS   = 2;
  localparam int unsigned SPP_FRAME_BITS  = 1 + SPP_DATA_BITS + 1 + SPP_STOP_BITS;
  localparam int unsigned SPP_BREAK_BITS  = 12;
  // direction change
  localparam int unsigned SPP_GUARD_MIN   = 2;
  localparam logic [7:0]  SPP_GUARD_RESET = 8'h80;
  // message lengths
  localparam logic [7:0]  SPP_KEY_OPCODE  = 8'hE0;
  localparam logic [3:0]  SPP_KEY_OPERANDS = 4'h8;
  localparam logic [3:0]  SPP_STD_OPERANDS = 4'h1;
  // idle counter width and reset values
  localparam int unsigned SPP_CNT_W       = 9;
  localparam logic        SPP_LINE_IDLE   = 1'b1;

  typedef enum logic [1:0] {SPP_RX_MODE, SPP_TX_GUARD, SPP_TX_SHIFT} spp_phy_mode_type;
endpackage

// ### rtl/spp_sync.sv
/*
  Two-flop synchroniser for a level that arrives from outside the
  clock domain.
  Assumes the input is a plain level; the first flop feeds only the second.
*/
`timescale 1ns/10ps
module spp_sync
  import spp_pkg::*;
#(
  parameter logic RESET_VAL = 1'b0
)(
  input  wire logic clock,
  input  wire logic rst_b,
  input  wire logic async_in,
  output logic      sync_out
);
  logic meta_r;
  logic meta_nxt;
  logic sync_nxt;

  // ---------------------------------------------------------------
  // two register stages
  // ---------------------------------------------------------------
  always_comb
  begin
    meta_nxt = async_in;
    sync_nxt = meta_r;
  end

  always_ff @(posedge clock or negedge rst_b)
  begin
    if (!rst_b)
    begin
      meta_r   <= RESET_VAL;
      sync_out <= RESET_VAL;
    end
    else
    begin
      meta_r   <= meta_nxt;
      sync_out <= sync_nxt;
    end
  end
endmodule

// ### tb/spp_prog_model.sv
/*
  Behavioural programmer for the serial programming port: makes the
  programmer clock and drives or releases the data line, frame by frame.
  Assumes the bench resolves the wire from both enables, with a pull-up.
*/
`timescale 1ns/10ps
module spp_prog_model (
  output logic      prog_clk,
  output logic      drv_oe,
  output logic      drv_val,
  input  wire logic line,
  input  wire logic dev_oe
);
  // ----------------------------------------
  // bit clocking
  // ----------------------------------------
  // clock stands high between frames, line released
  initial
  begin
    prog_clk = 1'b1;
    drv_oe = 1'b0;
    drv_val = 1'b1;
  end

  // change on the fall, sample on the rise
  // edges sit 2 ns past the system clock edge so sampling never races them
  task automatic bit_cyc(input logic drv, input logic v, output logic s, output logic o);
    #2;
    prog_clk = 1'b0;
    drv_oe = drv;
    drv_val = v;
    #80;
    prog_clk = 1'b1;
    s = line;
    o = dev_oe;
    #78;
  endtask

  // released bits; pull-up holds the line high
  task automatic idle(input int n);
    logic s, o;
    repeat (n) bit_cyc(1'b0, 1'b1, s, o);
  endtask

  // start, lsb first data, even parity, two stops
  task automatic send(input logic [7:0] d, input logic bad_par, input logic bad_stop);
    logic [11:0] f;
    logic        s, o;
    f = {1'b1, ~bad_stop, ^d ^ bad_par, d, 1'b0};
    for (int i = 0; i < 12; i++)
      bit_cyc(1'b1, f[i], s, o);
  endtask

  // twelve low bit periods
  task automatic brk();
    logic s, o;
    repeat (12) bit_cyc(1'b1, 1'b0, s, o);
    idle(2);
  endtask

  // collect one reply; pull the line low at bit k to force a contention
  task automatic recv(input int k, output int idl, output logic [11:0] b,
                      output logic [11:0] oe);
    logic s, o;
    idl = 0;
    bit_cyc(1'b0, 1'b1, s, o);
    while (s !== 1'b0 && idl < 400)
    begin
      idl++;
      bit_cyc(1'b0, 1'b1, s, o);
    end
    b[0] = s;
    oe[0] = o;
    for (int i = 1; i < 12; i++)
    begin
      bit_cyc(i == k, 1'b0, s, o);
      b[i] = s;
      oe[i] = o;
    end
    idle(1);
  endtask
endmodule

// ### tb/tb.sv
/*
  Self-checking bench for the serial programming port link: write, key and
  read messages, guard lengths, exceptions, collision and break recovery.
  Assumes the link's package and a programmer model beside it.
*/
`timescale 1ns/10ps
module tb;
  import spp_pkg::*;
  logic        clock, rst_b, guard_load, instr_is_read, tx_byte_req, line;
  logic        prog_clk, drv_oe, drv_val, out, oe, rx_valid, rx_is_instr;
  logic        frame_err, parity_err, break_seen, collision, error_state, tx_mode;
  logic [7:0]  guard_time, tx_val, rx_byte, last_rx;
  logic [11:0] b, oe_seen, f;
  int          failures, checks, n_rx, n_ins, n_par, n_frm, n_brk, n_col, n_req, idl, n0;
  logic [7:0]  gt [3] = '{SPP_GUARD_RESET, 8'h00, 8'h03};
  logic [7:0]  tv [3] = '{8'hA6, 8'h3C, 8'h81};

  // ----------------------------------------
  // clock, wire, instances
  // ----------------------------------------
  always #5 clock = ~clock;
  // pull-up wins only when nobody drives
  assign line = (oe ? out : 1'b1) & (drv_oe ? drv_val : 1'b1);

  spp_link dut (.clock(clock), .rst_b(rst_b), .prog_clk(prog_clk),
    .prog_data_line_in(line), .prog_data_line_out(out), .prog_data_line_oe(oe),
    .guard_time(guard_time), .guard_load(guard_load), .instr_is_read(instr_is_read),
    .tx_byte(tx_val), .tx_byte_req(tx_byte_req), .rx_byte(rx_byte),
    .rx_valid(rx_valid), .rx_is_instr(rx_is_instr), .frame_err(frame_err),
    .parity_err(parity_err), .break_seen(break_seen), .collision(collision),
    .error_state(error_state), .tx_mode(tx_mode));
  spp_prog_model prog (.prog_clk(prog_clk), .drv_oe(drv_oe), .drv_val(drv_val),
    .line(line), .dev_oe(oe));

  // pulses are counted here so no one-cycle event is missed
  always @(posedge clock)
  begin
    if (rx_valid)
    begin
      n_rx++;
      last_rx = rx_byte;
      if (rx_is_instr)
        n_ins++;
    end
    n_par += parity_err;
    n_frm += frame_err;
    n_brk += break_seen;
    n_col += collision;
    n_req += tx_byte_req;
  end

  // ----------------------------------------
  // tasks
  // ----------------------------------------
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp)
    begin
      failures++;
      $display("CHECK FAILED at %0t: got %0h expected %0h", $time, got, exp);
    end
  endtask

  task automatic test_done();
    $display("failures %0d checks %0d", failures, checks);
    if (failures == 0 && checks > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  task automatic wr(input logic [7:0] d);
    prog.send(d, 1'b0, 1'b0);
    prog.idle(1);
  endtask

  // read message: instruction out, reply collected with no gap
  task automatic rd(input logic [7:0] v, input int k);
    @(posedge clock);
    tx_val <= v;
    instr_is_read <= 1'b1;
    prog.send(8'h80, 1'b0, 1'b0);
    prog.recv(k, idl, b, oe_seen);
    @(posedge clock);
    instr_is_read <= 1'b0;
  endtask

  // ----------------------------------------
  // tests
  // ----------------------------------------
  initial
  begin
    clock = 1'b0;
    rst_b = 1'b0;
    guard_load = 1'b0;
    instr_is_read = 1'b0;
    guard_time = 8'h00;
    tx_val = 8'h00;
    repeat (3) @(posedge clock);
    rst_b <= 1'b1;
    prog.idle(16);
    chk(error_state, 1'b0);
    chk(tx_mode, 1'b0);
    chk(oe, 1'b0);
    // write message, then key message with eight operands
    wr(8'hC3);
    wr(8'h5A);
    chk(last_rx, 8'h5A);
    wr(8'hE0);
    for (int i = 1; i <= 8; i++)
      wr(8'h11 * i);
    wr(8'hC3);
    wr(8'h00);
    chk(n_rx, 13);
    chk(n_ins, 3);
    chk(n_brk, 0);
    // reads at default, minimum and small guard
    for (int j = 0; j < 3; j++)
    begin
      if (j > 0)
      begin
        @(posedge clock);
        guard_time <= gt[j];
        guard_load <= 1'b1;
        @(posedge clock);
        guard_load <= 1'b0;
      end
      rd(tv[j], -1);
      f = {2'b11, ^tv[j], tv[j], 1'b0};
      chk(idl, gt[j] + 2);
      chk(b, f);
      chk(oe_seen, {~f[10:0] | ~f[11:1], 1'b1});
    end
    // contention on a released one stops the reply
    rd(8'hFF, 3);
    chk(n_col, 1);
    chk(n_req, 4);
    chk({error_state, tx_mode}, 2'b10);
    n0 = n_rx;
    wr(8'h12);
    chk(n_rx, n0);
    n0 = n_brk;
    prog.brk();
    chk(n_brk, n0 + 1);
    chk(error_state, 1'b0);
    // parity error, then double break resync
    prog.send(8'h34, 1'b1, 1'b0);
    prog.idle(1);
    chk(n_par, 1);
    chk(error_state, 1'b1);
    prog.brk();
    prog.brk();
    chk(error_state, 1'b0);
    // frame error on first stop
    prog.send(8'h34, 1'b0, 1'b1);
    prog.idle(1);
    chk(n_frm, 1);
    chk(error_state, 1'b1);
    prog.brk();
    wr(8'hC3);
    wr(8'h77);
    chk(last_rx, 8'h77);
    test_done();
  end

  // a hang costs far more than the ~88 us the tests need
  initial
  begin
    #600000;
    failures++;
    test_done();
  end
endmodule
